// file: rtl/iobsd_pkg.sv
// package: constants for the banked i/o register decoder
package iobsd_pkg;
  localparam int          DW            = 16;
  localparam int          PW            = 3;
  localparam int          AW            = 12;
  localparam logic [2:0]  PORT_BANKSEL  = 3'h7;
  localparam logic [15:0] BANK_EXT      = 16'hFFFF;
  localparam logic [15:0] BANKSEL_RST   = 16'h0000;
  localparam logic [15:0] ZERO16        = 16'h0000;
  localparam logic [8:0]  ADDR_HI_IO    = 9'h1FF;
  localparam logic [2:0]  BANK_BITIO    = 3'h0;
  localparam logic [2:0]  BANK_WDOG     = 3'h1;
  localparam logic [2:0]  BANK_TIMER    = 3'h2;
  localparam logic [2:0]  BANK_CMP      = 3'h3;
  localparam logic [2:0]  BANK_ACT      = 3'h4;
  localparam logic [2:0]  BANK_SER      = 3'h5;
  localparam logic [2:0]  BANK_CAP      = 3'h6;
  localparam logic [2:0]  BANK_SER2     = 3'h7;
  // bank 0 ports
  localparam logic [2:0]  P_LATCH       = 3'h0;
  localparam logic [2:0]  P_DIR         = 3'h1;
  localparam logic [2:0]  P_BITSET      = 3'h2;
  localparam logic [2:0]  P_BITCLR      = 3'h3;
  localparam logic [2:0]  P_IFLAG       = 3'h4;
  localparam logic [2:0]  P_IMASK       = 3'h5;
  localparam logic [2:0]  P_FLAGCLR     = 3'h6;
  // bank 1 ports
  localparam logic [2:0]  P_WCNT        = 3'h0;
  localparam logic [2:0]  P_WDPER       = 3'h1;
  localparam logic [2:0]  P_WLAT        = 3'h2;
  localparam logic [2:0]  P_SYSCFG      = 3'h3;
  // bank 5/6 ports
  localparam logic [2:0]  P_SERCTL      = 3'h0;
  localparam logic [2:0]  P_SERSET      = 3'h1;
  localparam logic [2:0]  P_SERCLR      = 3'h2;
  localparam logic [2:0]  P_CAPCTL      = 3'h4;
  localparam logic [2:0]  P_CAPCLR      = 3'h5;
  localparam logic [15:0] SYSCFG_RST    = 16'hFFFF;
  typedef enum logic [1:0] {
    IOBSD_IDLE = 2'b00,
    IOBSD_CYC1 = 2'b01,
    IOBSD_CYC2 = 2'b11
  } iobsd_state_t;
endpackage

// file: rtl/iobsd_setclr.sv
// set/clear helper register: masked set and clear of a 16-bit register
`timescale 1ns/1ps
module iobsd_setclr
  import iobsd_pkg::*;
#(
  parameter int          W   = 16,
  parameter logic [15:0] RST = 16'h0000
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         wr_i,
  input  wire logic         set_i,
  input  wire logic         clr_i,
  input  wire logic [W-1:0] data_i,
  input  wire logic [W-1:0] hw_set_i,
  output logic      [W-1:0] q_o
);
  // refuse widths that the reset value and the shared data path cannot cover
  if (W < 1 || W > DW) begin : g_bad_width
    $error("iobsd_setclr width out of range");
  end
  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q_o <= RST[W-1:0];
    end else if (wr_i) begin
      q_o <= data_i | hw_set_i;
    end else if (set_i) begin
      q_o <= q_o | data_i | hw_set_i;
    end else if (clr_i) begin
      q_o <= (q_o & ~data_i) | hw_set_i;
    end else begin
      q_o <= q_o | hw_set_i;
    end
  end
endmodule

// file: rtl/iobsd_wdog.sv
// watchdog counter that runs against a latched copy of its period
`timescale 1ns/1ps
module iobsd_wdog
  import iobsd_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          cnt_wr_i,
  input  wire logic          per_wr_i,
  input  wire logic [DW-1:0] data_i,
  output logic      [DW-1:0] count_o,
  output logic      [DW-1:0] period_o,
  output logic      [DW-1:0] latch_o
);
  logic wrap;
  assign wrap = (count_o == latch_o);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      period_o <= ZERO16;
    end else if (per_wr_i) begin
      period_o <= data_i;
    end
  end
  // new period only takes effect at a wrap, never mid-period
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      latch_o <= ZERO16;
    end else if (wrap) begin
      latch_o <= period_o;
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_o <= ZERO16;
    end else if (cnt_wr_i) begin
      count_o <= data_i;
    end else if (wrap) begin
      count_o <= ZERO16;
    end else begin
      count_o <= count_o + 16'h0001;
    end
  end
endmodule

// file: rtl/iobsd_top.sv
// banked i/o decoder: bank select, on-chip registers, external strobes
// Function
// - read strobe low for every external in and external fetch
// - data bus floats except while write strobe low
// - external out drives write strobe in cycle one
// - external table write strobes in cycle two
// - on-chip access keeps write strobe high
// - eight ports, 16-bit in and out each
// - bank chosen by bank select, port picks register
// - bank selection persists across accesses
// - out data always placed on data bus
// - port 7 always reaches bank select
// - low three bits pick on-chip bank
// - all ones routes ports 0-6 external
// - bit set helper sets latch bits
// - bit clear helper clears latch bits
// - flag clear helper clears flag bits
// - capture clear helper clears capture bits
// - serial set/clear helpers modify serial control
// - watchdog counts against latched old period
// - port on low address lines, upper high
// - on-chip transfers assert no external strobe
`timescale 1ns/1ps
module iobsd_top
  import iobsd_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          in_req_i,
  input  wire logic          out_req_i,
  input  wire logic          table_write_req_i,
  input  wire logic          fetch_ext_i,
  input  wire logic [PW-1:0] port_i,
  input  wire logic [AW-1:0] pc_addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [DW-1:0] flag_set_i,
  input  wire logic [DW-1:0] cap_set_i,
  input  wire logic [DW-1:0] ext_data_bus_i,
  output logic      [DW-1:0] rdata_o,
  output logic               rvalid_o,
  output logic      [AW-1:0] addr_o,
  output logic               ext_rd_n_o,
  output logic               ext_wr_n_o,
  output logic      [DW-1:0] ext_data_bus_o,
  output logic               ext_data_bus_oe_o,
  output logic      [DW-1:0] bank_select_o,
  output logic      [DW-1:0] bit_io_latch_o
);
  //////////////////////////////////////////////////////////////////////////
  // decode
  iobsd_state_t state_r, state_nxt;
  logic [DW-1:0] bank_select_r;
  logic [DW-1:0] bit_dir_r, irq_mask_r, syscfg_r;
  logic [DW-1:0] irq_flags, cap_ctl, ser_ctl, wd_cnt, wd_per, wd_lat;
  logic [DW-1:0] table_wr_data_r;
  logic          is_banksel, is_ext, bank_ok;
  logic [2:0]    bank;

  // bank number for on-chip use is valid only when upper bits are zero
  function automatic logic bank_valid(input logic [DW-1:0] b);
    return (b[DW-1:3] == 13'h0000);
  endfunction

  function automatic logic hit(input logic [2:0] bk, input logic [2:0] pt,
                               input logic [2:0] wb, input logic [2:0] wp);
    return (bk == wb) && (pt == wp);
  endfunction

  assign bank       = bank_select_r[2:0];
  assign is_banksel = (port_i == PORT_BANKSEL);
  assign is_ext     = !is_banksel && (bank_select_r == BANK_EXT);
  assign bank_ok    = !is_banksel && bank_valid(bank_select_r);

  logic on_wr;
  assign on_wr = out_req_i && bank_ok;

  //////////////////////////////////////////////////////////////////////////
  // bank select, persists until rewritten
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bank_select_r <= BANKSEL_RST;
    end else if (out_req_i && is_banksel) begin
      bank_select_r <= wdata_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // plain read/write registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bit_dir_r  <= ZERO16;
      irq_mask_r <= ZERO16;
      syscfg_r   <= SYSCFG_RST;
    end else begin
      if (on_wr && hit(bank, port_i, BANK_BITIO, P_DIR)) begin
        bit_dir_r <= wdata_i;
      end
      if (on_wr && hit(bank, port_i, BANK_BITIO, P_IMASK)) begin
        irq_mask_r <= wdata_i;
      end
      if (on_wr && hit(bank, port_i, BANK_WDOG, P_SYSCFG)) begin
        syscfg_r <= wdata_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // set/clear helper registers
  iobsd_setclr #(.W(DW), .RST(ZERO16)) u_latch (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .wr_i     (on_wr && hit(bank, port_i, BANK_BITIO, P_LATCH)),
    .set_i    (on_wr && hit(bank, port_i, BANK_BITIO, P_BITSET)),
    .clr_i    (on_wr && hit(bank, port_i, BANK_BITIO, P_BITCLR)),
    .data_i   (wdata_i),
    .hw_set_i (ZERO16),
    .q_o      (bit_io_latch_o)
  );

  iobsd_setclr #(.W(DW), .RST(ZERO16)) u_flags (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .wr_i     (1'b0),
    .set_i    (1'b0),
    .clr_i    (on_wr && hit(bank, port_i, BANK_BITIO, P_FLAGCLR)),
    .data_i   (wdata_i),
    .hw_set_i (flag_set_i),
    .q_o      (irq_flags)
  );

  iobsd_setclr #(.W(DW), .RST(ZERO16)) u_cap (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .wr_i     (on_wr && hit(bank, port_i, BANK_CAP, P_CAPCTL)),
    .set_i    (1'b0),
    .clr_i    (on_wr && hit(bank, port_i, BANK_CAP, P_CAPCLR)),
    .data_i   (wdata_i),
    .hw_set_i (cap_set_i),
    .q_o      (cap_ctl)
  );

  iobsd_setclr #(.W(DW), .RST(ZERO16)) u_ser (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .wr_i     (on_wr && hit(bank, port_i, BANK_SER, P_SERCTL)),
    .set_i    (on_wr && hit(bank, port_i, BANK_SER, P_SERSET)),
    .clr_i    (on_wr && hit(bank, port_i, BANK_SER, P_SERCLR)),
    .data_i   (wdata_i),
    .hw_set_i (ZERO16),
    .q_o      (ser_ctl)
  );

  iobsd_wdog u_wdog (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .cnt_wr_i (on_wr && hit(bank, port_i, BANK_WDOG, P_WCNT)),
    .per_wr_i (on_wr && hit(bank, port_i, BANK_WDOG, P_WDPER)),
    .data_i   (wdata_i),
    .count_o  (wd_cnt),
    .period_o (wd_per),
    .latch_o  (wd_lat)
  );

  //////////////////////////////////////////////////////////////////////////
  // read mux; timer, compare and serial data registers live elsewhere
  logic [DW-1:0] on_rd;
  always_comb begin
    on_rd = ZERO16;
    if (bank_ok) begin
      case ({bank, port_i})
        {BANK_BITIO, P_LATCH}:  on_rd = bit_io_latch_o;
        {BANK_BITIO, P_DIR}:    on_rd = bit_dir_r;
        {BANK_BITIO, P_IFLAG}:  on_rd = irq_flags;
        {BANK_BITIO, P_IMASK}:  on_rd = irq_mask_r;
        {BANK_WDOG, P_WCNT}:    on_rd = wd_cnt;
        {BANK_WDOG, P_WDPER}:   on_rd = wd_per;
        {BANK_WDOG, P_WLAT}:    on_rd = wd_lat;
        {BANK_WDOG, P_SYSCFG}:  on_rd = syscfg_r;
        {BANK_SER, P_SERCTL}:   on_rd = ser_ctl;
        {BANK_CAP, P_CAPCTL}:   on_rd = cap_ctl;
        default:                on_rd = ZERO16;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // instruction cycle tracking for table write (second cycle strobes)
  always_comb begin
    case (state_r)
      IOBSD_IDLE: state_nxt = table_write_req_i ? IOBSD_CYC1 : IOBSD_IDLE;
      IOBSD_CYC1: state_nxt = IOBSD_CYC2;
      IOBSD_CYC2: state_nxt = IOBSD_IDLE;
      default:    state_nxt = IOBSD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r         <= IOBSD_IDLE;
      table_wr_data_r <= ZERO16;
    end else begin
      state_r <= state_nxt;
      if (table_write_req_i && state_r == IOBSD_IDLE) begin
        table_wr_data_r <= wdata_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // external pins, all registered
  logic wr_n_nxt;
  always_comb begin
    wr_n_nxt = 1'b1;
    if (out_req_i && is_ext) wr_n_nxt = 1'b0;
    if (state_r == IOBSD_CYC1) wr_n_nxt = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ext_wr_n_o        <= 1'b1;
      ext_rd_n_o        <= 1'b1;
      ext_data_bus_o    <= ZERO16;
      ext_data_bus_oe_o <= 1'b0;
      addr_o            <= ZERO16[AW-1:0];
      rdata_o           <= ZERO16;
      rvalid_o          <= 1'b0;
      bank_select_o     <= BANKSEL_RST;
    end else begin
      ext_wr_n_o        <= wr_n_nxt;
      ext_rd_n_o        <= !((in_req_i && is_ext) || fetch_ext_i);
      ext_data_bus_oe_o <= !wr_n_nxt;
      // internal bus copy always carries out data, even on-chip
      if (out_req_i) begin
        ext_data_bus_o <= wdata_i;
      end else if (state_r == IOBSD_CYC1) begin
        ext_data_bus_o <= table_wr_data_r;
      end
      if (in_req_i || out_req_i) begin
        addr_o <= {ADDR_HI_IO, port_i};
      end else begin
        addr_o <= pc_addr_i;
      end
      rvalid_o      <= in_req_i;
      bank_select_o <= bank_select_r;
      if (in_req_i) begin
        rdata_o <= is_banksel ? bank_select_r : (is_ext ? ext_data_bus_i : on_rd);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_bus_float;
    @(posedge clk_i) disable iff (reset_i) ext_data_bus_oe_o == !ext_wr_n_o;
  endproperty
  a_bus_float: assert property (p_bus_float) else $error("bus driven without strobe");

  property p_out_ext;
    @(posedge clk_i) disable iff (reset_i)
      (out_req_i && port_i != PORT_BANKSEL && bank_select_r == BANK_EXT) |=> !ext_wr_n_o;
  endproperty
  a_out_ext: assert property (p_out_ext) else $error("external out without strobe");

  property p_table_wr;
    @(posedge clk_i) disable iff (reset_i)
      (table_write_req_i && state_r == IOBSD_IDLE) |=> ##1 !ext_wr_n_o;
  endproperty
  a_table_wr: assert property (p_table_wr) else $error("table write strobe missing");

  property p_onchip;
    @(posedge clk_i) disable iff (reset_i)
      (out_req_i && bank_select_r != BANK_EXT && state_r != IOBSD_CYC1) |=> ext_wr_n_o;
  endproperty
  a_onchip: assert property (p_onchip) else $error("on-chip access strobed");

  property p_rd;
    @(posedge clk_i) disable iff (reset_i) fetch_ext_i |=> !ext_rd_n_o;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe missing");

  property p_banksel;
    @(posedge clk_i) disable iff (reset_i)
      (out_req_i && port_i == PORT_BANKSEL) |=> bank_select_r == $past(wdata_i);
  endproperty
  a_banksel: assert property (p_banksel) else $error("bank select not written");

  property p_data;
    @(posedge clk_i) disable iff (reset_i) out_req_i |=> ext_data_bus_o == $past(wdata_i);
  endproperty
  a_data: assert property (p_data) else $error("out data not on bus");

  property p_addr;
    @(posedge clk_i) disable iff (reset_i)
      in_req_i |=> addr_o == {ADDR_HI_IO, $past(port_i)};
  endproperty
  a_addr: assert property (p_addr) else $error("port address wrong");

  property p_bad;
    @(posedge clk_i) disable iff (reset_i)
      (in_req_i && port_i != PORT_BANKSEL && !bank_valid(bank_select_r)
       && bank_select_r != BANK_EXT) |=> rdata_o == ZERO16;
  endproperty
  a_bad: assert property (p_bad) else $error("invalid bank read nonzero");

  property p_bit_set;
    @(posedge clk_i) disable iff (reset_i)
      (on_wr && hit(bank, port_i, BANK_BITIO, P_BITSET))
      |=> bit_io_latch_o == ($past(bit_io_latch_o) | $past(wdata_i));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set helper wrong");

  property p_bit_clr;
    @(posedge clk_i) disable iff (reset_i)
      (on_wr && hit(bank, port_i, BANK_BITIO, P_BITCLR))
      |=> bit_io_latch_o == ($past(bit_io_latch_o) & ~$past(wdata_i));
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("bit clear helper wrong");

  // a flag raised by hardware in the clearing cycle survives the clear
  property p_flag_clr;
    @(posedge clk_i) disable iff (reset_i)
      (on_wr && hit(bank, port_i, BANK_BITIO, P_FLAGCLR))
      |=> irq_flags == (($past(irq_flags) & ~$past(wdata_i)) | $past(flag_set_i));
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag clear helper wrong");

  property p_cap_clr;
    @(posedge clk_i) disable iff (reset_i)
      (on_wr && hit(bank, port_i, BANK_CAP, P_CAPCLR))
      |=> cap_ctl == (($past(cap_ctl) & ~$past(wdata_i)) | $past(cap_set_i));
  endproperty
  a_cap_clr: assert property (p_cap_clr) else $error("capture clear helper wrong");

  property p_ser_set;
    @(posedge clk_i) disable iff (reset_i)
      (on_wr && hit(bank, port_i, BANK_SER, P_SERSET))
      |=> ser_ctl == ($past(ser_ctl) | $past(wdata_i));
  endproperty
  a_ser_set: assert property (p_ser_set) else $error("serial set helper wrong");

  property p_wd_hold;
    @(posedge clk_i) disable iff (reset_i) (wd_cnt != wd_lat) |=> wd_lat == $past(wd_lat);
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("period latch moved mid-period");

  property p_rd_onchip;
    @(posedge clk_i) disable iff (reset_i) (in_req_i && !is_ext && !fetch_ext_i) |=> ext_rd_n_o;
  endproperty
  a_rd_onchip: assert property (p_rd_onchip) else $error("on-chip read strobed");

  c_ext_out:  cover property (@(posedge clk_i) out_req_i && is_ext);
  c_ext_in:   cover property (@(posedge clk_i) in_req_i && is_ext);
  c_table_wr: cover property (@(posedge clk_i) state_r == IOBSD_CYC2);
  c_bitset:   cover property (@(posedge clk_i) on_wr && hit(bank, port_i, BANK_BITIO, P_BITSET));
endmodule

// file: tb/iobsd_ext_model.sv
// off-chip peripherals and program memory on the parallel bus
`timescale 1ns/1ps
module iobsd_ext_model
  import iobsd_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rd_n_i,
  input  wire logic          wr_n_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] data_i,
  output logic      [DW-1:0] bus_o,
  output logic      [DW-1:0] wdata_o,
  output logic      [AW-1:0] waddr_o
);
  logic [DW-1:0] mem_r [8];
  logic [DW-1:0] bus_r = 16'h3C5A;
  assign bus_o = bus_r;
  ////////////////////////////////////////////////////////////////////////////////
  // released bus toggles every cycle so a stale value never looks valid
  always @(posedge clk_i) begin
    if (rd_n_i === 1'b0) begin
      bus_r <= mem_r[addr_i[2:0]];
    end else begin
      bus_r <= ~bus_r;
    end
    if (wr_n_i === 1'b0) begin
      mem_r[addr_i[2:0]] <= data_i;
      wdata_o <= data_i;
      waddr_o <= addr_i;
    end
  end
endmodule

// file: tb/iobsd_top_test.sv
// testbench: banked i/o decoder against a behavioural register model
`timescale 1ns/1ps
module iobsd_top_test
  import iobsd_pkg::*;
  ;
  logic          clk_i       = 1'b0;
  logic          reset_i     = 1'b1;
  logic          in_req_i    = 1'b0;
  logic          out_req_i   = 1'b0;
  logic          table_write_req_i = 1'b0;
  logic          fetch_ext_i = 1'b0;
  logic [PW-1:0] port_i      = 3'h0;
  logic [AW-1:0] pc_addr_i   = 12'h000;
  logic [DW-1:0] wdata_i     = 16'h0000;
  logic [DW-1:0] flag_set_i  = 16'h0000;
  logic [DW-1:0] cap_set_i   = 16'h0000;
  logic [DW-1:0] ext_data_bus_i, rdata_o, ext_data_bus_o, bank_select_o;
  logic [DW-1:0] bit_io_latch_o, ext_wdata, smp;
  logic [AW-1:0] addr_o, ext_waddr, rd_addr;
  logic          rvalid_o, ext_rd_n_o, ext_wr_n_o, ext_data_bus_oe_o;
  int            fail_count = 0, num_checks = 0, rel = 0, wr_cnt = 0, rd_cnt = 0;
  int            wr_rel = 0, out_rel = 0, wr0, rd0, bsel = 0, m [64];
  logic [31:0]   seed = 32'hB7A9;
  int            bk [6] = '{0, 1, 2, 5, 6, 'h2005};
  logic [6:0]    wm [6] = '{7'h7F, 7'h0A, 7'h7F, 7'h07, 7'h20, 7'h7F};
  logic [6:0]    rm [6] = '{7'h33, 7'h0A, 7'h7F, 7'h01, 7'h10, 7'h7F};

  iobsd_top DUT (.clk_i(clk_i), .reset_i(reset_i), .in_req_i(in_req_i),
    .out_req_i(out_req_i), .table_write_req_i(table_write_req_i), .fetch_ext_i(fetch_ext_i),
    .port_i(port_i), .pc_addr_i(pc_addr_i), .wdata_i(wdata_i), .flag_set_i(flag_set_i),
    .cap_set_i(cap_set_i), .ext_data_bus_i(ext_data_bus_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .addr_o(addr_o), .ext_rd_n_o(ext_rd_n_o), .ext_wr_n_o(ext_wr_n_o),
    .ext_data_bus_o(ext_data_bus_o), .ext_data_bus_oe_o(ext_data_bus_oe_o),
    .bank_select_o(bank_select_o), .bit_io_latch_o(bit_io_latch_o));
  iobsd_ext_model u_ext (.clk_i(clk_i), .rd_n_i(ext_rd_n_o), .wr_n_i(ext_wr_n_o),
    .addr_i(addr_o), .data_i(ext_data_bus_o), .bus_o(ext_data_bus_i),
    .wdata_o(ext_wdata), .waddr_o(ext_waddr));

  always #2.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  // strobe monitor: counts strobe cycles and the write strobe's offset from the request
  always @(posedge clk_i) begin
    if (in_req_i | out_req_i | table_write_req_i) rel <= 0;
    else rel <= rel + 1;
  end
  always @(negedge clk_i) begin
    if (!reset_i && ext_data_bus_oe_o !== ~ext_wr_n_o) begin
      fail_count++;
      $display("Error bus enable expected %b seen %b", ~ext_wr_n_o, ext_data_bus_oe_o);
    end
    if (ext_wr_n_o === 1'b0) begin
      wr_cnt++;
      wr_rel = rel;
    end
    if (ext_rd_n_o === 1'b0) begin
      rd_cnt++;
      rd_addr = addr_o;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  // register model: bank select, plain registers, set/clear helpers
  function automatic void mwr(int p, int d);
    int k;
    k = bsel * 8 + p;
    if (p == 7) bsel = d;
    else if (bsel < 8) begin
      case (k)
        2: m[0] |= d;
        3: m[0] &= ~d;
        6: m[4] &= ~d;
        41: m[40] |= d;
        42: m[40] &= ~d;
        53: m[52] &= ~d;
        0, 1, 5, 9, 11, 40: m[k] = d;
        default: ;
      endcase
    end
  endfunction
  function automatic int mrd(int p);
    if (p == 7) return bsel;
    if (bsel > 7) return 0;
    return m[bsel * 8 + p];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_data(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_count(input string n, input int e, input int g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // out or table write; waits past the second strobe cycle
  task automatic op_out(input logic [2:0] p, input logic [15:0] d, input bit tw);
    bit ext;
    ext = tw || (bsel == 'hFFFF && p != 3'h7);
    wr0 = wr_cnt;
    port_i <= p;
    wdata_i <= d;
    if (tw) table_write_req_i <= 1'b1;
    else out_req_i <= 1'b1;
    @(posedge clk_i);
    table_write_req_i <= 1'b0;
    out_req_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    if (!tw) mwr(p, d);
    chk_data("bus out", d, ext_data_bus_o);
    chk_data("bank select", 16'(bsel), bank_select_o);
    if (ext) begin
      chk_count("wr strobes", 1, wr_cnt - wr0);
      chk_data("ext wdata", d, ext_wdata);
      if (!tw) chk_data("ext addr", {4'h0, 9'h1FF, p}, {4'h0, ext_waddr});
      if (!tw) out_rel = wr_rel;
    end else if (bsel < 8 || p == 3'h7) begin
      chk_count("wr strobes", 0, wr_cnt - wr0);
    end
  endtask
  task automatic op_in(input logic [2:0] p, output logic [15:0] q);
    int n;
    wr0 = wr_cnt;
    rd0 = rd_cnt;
    n = 0;
    port_i <= p;
    in_req_i <= 1'b1;
    @(posedge clk_i);
    smp = ext_data_bus_i;
    in_req_i <= 1'b0;
    do begin
      @(negedge clk_i);
      n++;
    end while (rvalid_o !== 1'b1 && n < 4);
    q = rdata_o;
    chk_count("read valid", 1, int'(rvalid_o === 1'b1));
    repeat (3) @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [2:0] p);
    logic [15:0] q;
    op_in(p, q);
    if (p != 3'h7 && bsel == 'hFFFF) begin
      chk_data("ext read", smp, q);
      chk_count("rd strobes", 1, rd_cnt - rd0);
    end else begin
      chk_data("reg read", 16'(mrd(p)), q);
      if (bsel < 8 || p == 3'h7) chk_count("strobes", 0, rd_cnt - rd0 + wr_cnt - wr0);
    end
  endtask
  task automatic hwset();
    logic [15:0] f, c;
    f = rnd() & rnd();
    c = rnd() & rnd();
    flag_set_i <= f;
    cap_set_i <= c;
    @(posedge clk_i);
    flag_set_i <= 16'h0000;
    cap_set_i <= 16'h0000;
    @(posedge clk_i);
    m[4] |= f;
    m[52] |= c;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    $display("Error run time expected finish seen timeout");
    end_sim();
  end
  initial begin
    logic [15:0] q;
    int b, p;
    foreach (m[i]) m[i] = 0;
    m[11] = 'hFFFF;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    chk_data("idle strobes", 16'h0003, {14'h0000, ext_rd_n_o, ext_wr_n_o});
    rd_chk(3'h7);
    $display("test reset done");
    // watchdog: period latch keeps the old 0x0010 after a 0x0030 period write until the count wraps
    op_out(3'h7, 16'h0001, 1'b0);
    rd_chk(3'h3);
    op_out(3'h1, 16'h0010, 1'b0);
    op_out(3'h0, 16'hFFFF, 1'b0);
    op_out(3'h0, 16'h0000, 1'b0);
    op_out(3'h1, 16'h0030, 1'b0);
    op_in(3'h2, q);
    chk_data("period latch", 16'h0010, q);
    repeat (40) @(posedge clk_i);
    op_in(3'h2, q);
    chk_data("period latch", 16'h0030, q);
    $display("test watchdog done");
    for (int i = 0; i < 12; i++) begin
      b = i % 6;
      op_out(3'h7, 16'(bk[b]), 1'b0);
      for (int j = 0; j < 5; j++) begin
        hwset();
        p = rnd() % 7;
        while (!wm[b][p]) p = (p + 1) % 7;
        op_out(3'(p), rnd(), 1'b0);
        chk_data("latch out", 16'(m[0]), bit_io_latch_o);
        p = rnd() % 7;
        while (!rm[b][p]) p = (p + 1) % 7;
        rd_chk(3'(p));
      end
    end
    $display("test banks done");
    op_out(3'h7, 16'hFFFF, 1'b0);
    for (int k = 0; k < 7; k++) begin
      op_out(3'(k), rnd(), 1'b0);
      rd_chk(3'(k));
    end
    rd_chk(3'h7);
    chk_count("out strobe cycle", 0, out_rel);
    op_out(3'h0, rnd(), 1'b1);
    chk_count("table write strobe cycle", out_rel + 1, wr_rel);
    rd0 = rd_cnt;
    q = rnd();
    pc_addr_i <= q[11:0];
    fetch_ext_i <= 1'b1;
    @(posedge clk_i);
    fetch_ext_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk_count("fetch rd strobes", 1, rd_cnt - rd0);
    chk_data("fetch addr", {4'h0, q[11:0]}, {4'h0, rd_addr});
    $display("test external done");
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    bsel = 0;
    chk_data("bank select", 16'h0000, bank_select_o);
    $display("test second reset done");
    end_sim();
  end
endmodule
